// file: board_control_status_registers.sv
// board control and status register bank on the asynchronous memory bus
// Notes on behaviour
// - switches read in user bits 7:4, off=1
// - user bits 3:0 drive lamps, readable back
// - card register bit 7 shows card present
// - card bits 5:4 show card status lines
// - card bits 1:0 drive card control lines
// - card bit 3 holds card in reset
// - card leaves reset when sys_rst falls, bit clear
// - version bits 7:4 logic revision, bit 3 zero
// - version bits 2:0 board revision
// - routing bits 3:2 pick timer pin direction
// - routing bit 5 shows core power good
// - host held in reset while power bad
// - routing bit 4 masks power monitor reset
// - routing bits 1:0 send serial ports off-board
// - routing bits 7:6 read zero
// - bank at word 0x300000, 16-bit, low byte valid
`timescale 1ns/100ps
module board_control_status_registers
	import board_regs_pkg::*;
#(
	parameter logic [3:0] LOGIC_REVISION = 4'h1, // arbitrary value
	parameter logic [2:0] BOARD_REVISION = 3'h1  // arbitrary value
) (
	input  wire logic              core_clk,
	input  wire logic              sys_rst,
	input  wire logic [ADDR_W-1:0] bus_addr,
	input  wire logic              bus_select_n,
	input  wire logic              bus_read_n,
	input  wire logic              bus_write_n,
	input  wire logic [DATA_W-1:0] bus_wdata,
	output logic      [DATA_W-1:0] bus_rdata,
	output logic                   bus_rdata_en,
	input  wire logic [3:0]        switch_pins_n,
	output logic      [3:0]        lamp_drive,
	input  wire logic              card_present,
	input  wire logic [1:0]        card_status_in,
	output logic      [1:0]        card_control_out,
	output logic                   card_reset_out,
	input  wire logic              core_power_good,
	output logic                   host_reset_out,
	output logic      [1:0]        timer_pin_direction,
	output logic      [1:0]        serial_port_offboard,
	output logic                   power_monitor_mask
);
	typedef struct packed {
		logic [5:0]        sel_s1;
		logic [5:0]        sel_s2;
		logic [3:0]        sw_s1;
		logic [3:0]        sw_s2;
		logic [2:0]        card_s1;
		logic [2:0]        card_s2;
		logic              pg_s1;
		logic              pg_s2;
		logic              wr_prev;
		logic [3:0]        lamps;
		logic [1:0]        card_ctrl;
		logic              card_rst;
		logic [1:0]        ports;
		logic [1:0]        timers;
		logic              mon_mask;
		logic [DATA_W-1:0] rdata;
	} state_t;

	state_t s;
	state_t next_s;
	logic   hit;
	logic   wr_start;
	logic   rd_on;
	logic [1:0] idx;
	logic [REG_W-1:0] wbyte;
	logic [REG_W-1:0] rbyte;

	// bus strobes come from another chip: two flops before use
	always_comb begin
		next_s = s;
		next_s.sel_s1 = {bus_addr[ADDR_W-1:2] == BANK_BASE[ADDR_W-1:2], bus_addr[1:0],
			~bus_select_n, ~bus_read_n, ~bus_write_n};
		next_s.sel_s2 = s.sel_s1;
		next_s.sw_s1 = switch_pins_n;
		next_s.sw_s2 = s.sw_s1;
		next_s.card_s1 = {card_present, card_status_in};
		next_s.card_s2 = s.card_s1;
		next_s.pg_s1 = core_power_good;
		next_s.pg_s2 = s.pg_s1;
		hit = s.sel_s2[5] & s.sel_s2[2];
		idx = s.sel_s2[4:3];
		rd_on = hit & s.sel_s2[1];
		wr_start = hit & s.sel_s2[0] & ~s.wr_prev;
		next_s.wr_prev = hit & s.sel_s2[0];
		// data is stable by the time the synchronised strobe arrives
		wbyte = bus_wdata[REG_W-1:0];
		if (wr_start) begin
			unique case (idx)
				IDX_SWITCH_AND_LED: next_s.lamps = wbyte[LAMP_LSB +: 4];
				IDX_CARD_CONTROL: begin
					next_s.card_ctrl = wbyte[CARD_CTRL_LSB +: 2];
					next_s.card_rst  = wbyte[CARD_RESET_BIT];
				end
				IDX_BOARD_REV: ; // read-only
				IDX_ROUTING_POWER: begin
					next_s.ports    = wbyte[PORT_SEL_LSB +: 2];
					next_s.timers   = wbyte[TIMER_DIR_LSB +: 2];
					next_s.mon_mask = wbyte[MON_MASK_BIT];
				end
			endcase
		end
		rbyte = RESET_BYTE;
		unique case (idx)
			IDX_SWITCH_AND_LED: begin
				rbyte[SWITCH_LSB +: 4] = s.sw_s2;
				rbyte[LAMP_LSB +: 4]   = s.lamps;
			end
			IDX_CARD_CONTROL: begin
				rbyte[CARD_PRESENT_BIT]    = s.card_s2[2];
				rbyte[CARD_STATUS_LSB +: 2] = s.card_s2[1:0];
				rbyte[CARD_RESET_BIT]      = s.card_rst;
				rbyte[CARD_CTRL_LSB +: 2]  = s.card_ctrl;
			end
			IDX_BOARD_REV: begin
				rbyte[LOGIC_REV_LSB +: 4] = LOGIC_REVISION;
				rbyte[BOARD_REV_LSB +: 3] = BOARD_REVISION;
			end
			IDX_ROUTING_POWER: begin
				rbyte[POWER_GOOD_BIT]    = s.pg_s2;
				rbyte[MON_MASK_BIT]      = s.mon_mask;
				rbyte[TIMER_DIR_LSB +: 2] = s.timers;
				rbyte[PORT_SEL_LSB +: 2]  = s.ports;    // bits 7:6 stay 0
			end
		endcase
		next_s.rdata = {{(DATA_W-REG_W){1'b0}}, rbyte};
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// read enable is a handshake output, data comes from flops
	assign bus_rdata_en         = rd_on;
	assign bus_rdata            = s.rdata;
	assign lamp_drive           = s.lamps;
	assign card_control_out     = s.card_ctrl;
	assign card_reset_out       = s.card_rst | sys_rst;
	assign timer_pin_direction  = s.timers;
	assign serial_port_offboard = s.ports;
	assign power_monitor_mask   = s.mon_mask;
	assign host_reset_out       = ~s.pg_s2 & ~s.mon_mask;
endmodule : board_control_status_registers

// file: board_control_status_registers_checker.sv
// assertions on the register bank ports
`timescale 1ns/100ps
module board_control_status_registers_checker
	import board_regs_pkg::*;
(
	input wire logic              core_clk, sys_rst, bus_select_n, bus_write_n, bus_rdata_en,
	input wire logic              card_reset_out, core_power_good, host_reset_out,
	input wire logic              power_monitor_mask,
	input wire logic              bus_read_n,
	input wire logic [ADDR_W-1:0] bus_addr,
	input wire logic [DATA_W-1:0] bus_wdata, bus_rdata,
	input wire logic [3:0]        lamp_drive,
	input wire logic [1:0]        card_control_out, timer_pin_direction, serial_port_offboard
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);
	sequence s_wr(int i);
		!bus_select_n && !bus_write_n && bus_addr == BANK_BASE + i;
	endsequence
	sequence s_rd(int i);
		!bus_select_n && !bus_read_n && bus_addr == BANK_BASE + i;
	endsequence
	property p_rden; s_rd(3) [*3] |-> bus_rdata_en; endproperty
	a_rden: assert property (p_rden) else $error("read enable missing");
	property p_upper; bus_rdata[15:8] == 8'h00; endproperty
	a_upper: assert property (p_upper) else $error("upper byte set");
	property p_lamp; s_wr(0) [*5] |-> lamp_drive == bus_wdata[3:0]; endproperty
	a_lamp: assert property (p_lamp) else $error("lamp write");
	property p_card;
		s_wr(1) [*5] |-> {card_reset_out, card_control_out} == {bus_wdata[3], bus_wdata[1:0]};
	endproperty
	a_card: assert property (p_card) else $error("card write");
	property p_route;
		s_wr(3) [*5] |-> {power_monitor_mask, timer_pin_direction, serial_port_offboard}
			== bus_wdata[4:0];
	endproperty
	a_route: assert property (p_route) else $error("routing write");
	property p_mask; power_monitor_mask |-> !host_reset_out; endproperty
	a_mask: assert property (p_mask) else $error("masked reset");
	property p_pwr; !core_power_good [*3] ##0 !power_monitor_mask |-> host_reset_out; endproperty
	a_pwr: assert property (p_pwr) else $error("host not held");
	property p_idle; bus_select_n [*3] |-> !bus_rdata_en; endproperty
	a_idle: assert property (p_idle) else $error("bus driven idle");
	property p_rel; $fell(sys_rst) |-> !card_reset_out; endproperty
	a_rel: assert property (p_rel) else $error("card kept in reset");
endmodule : board_control_status_registers_checker

// file: board_control_status_registers_test.sv
// self-checking bench for the register bank
`timescale 1ns/100ps
module board_control_status_registers_test import board_regs_pkg::*;;
	logic core_clk = 0, sys_rst = 1, card_present = 0, core_power_good = 0;
	logic [3:0] switch_pins_n = 4'hA, lamp_drive;
	logic [1:0] card_status_in = 2'h2, card_control_out, timer_pin_direction, serial_port_offboard;
	logic card_reset_out, host_reset_out, power_monitor_mask, bus_rdata_en;
	logic bus_select_n, bus_read_n, bus_write_n;
	logic [ADDR_W-1:0] bus_addr;
	logic [DATA_W-1:0] bus_wdata, bus_rdata, q;
	int n_errors = 0, n_checks = 0, cyc = 0;
	always #50 core_clk = ~core_clk;
	board_control_status_registers #(.LOGIC_REVISION(4'h9), .BOARD_REVISION(3'h5))
		i_board_control_status_registers (.*);
	host_model i_host_model (.*);
	task automatic chk(input logic [15:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic results;
		if (n_errors == 0 && n_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : results
	task automatic t_user;
		i_host_model.acc(1, 3'h0, 8'hF5, q);
		chk(lamp_drive, 16'h5);
		i_host_model.acc(1, 3'h4, 8'hFF, q);
		i_host_model.acc(0, 3'h0, 8'h00, q);
		chk(q, 16'h00A5);
	endtask : t_user
	task automatic t_card;
		card_present = 1;
		i_host_model.acc(1, 3'h1, 8'hFF, q);
		chk({card_reset_out, card_control_out}, 16'h7);
		i_host_model.acc(0, 3'h1, 8'h00, q);
		chk(q, 16'h00AB);
		i_host_model.acc(1, 3'h2, 8'hFF, q);
		i_host_model.acc(0, 3'h2, 8'h00, q);
		chk(q, 16'h0095);
	endtask : t_card
	task automatic t_misc;
		core_power_good = 1;
		i_host_model.acc(1, 3'h3, 8'hFF, q);
		chk({power_monitor_mask, timer_pin_direction, serial_port_offboard}, 16'h1F);
		i_host_model.acc(0, 3'h3, 8'h00, q);
		chk(q, 16'h003F);
		core_power_good = 0;
		repeat (4) @(negedge core_clk);
		chk(host_reset_out, 16'h0);
		i_host_model.acc(1, 3'h3, 8'h00, q);
		chk(host_reset_out, 16'h1);
		i_host_model.acc(0, 3'h3, 8'h00, q);
		chk(q, 16'h0000);
	endtask : t_misc
	task automatic t_reset;
		i_host_model.acc(1, 3'h1, 8'hFF, q);
		sys_rst = 1;
		repeat (5) @(negedge core_clk);
		sys_rst = 0;
		@(negedge core_clk);
		chk({lamp_drive, card_control_out, card_reset_out, power_monitor_mask}, 16'h0);
	endtask : t_reset
	initial begin
		repeat (5) @(negedge core_clk);
		sys_rst = 0;
		t_user();
		t_card();
		t_misc();
		t_reset();
		results();
	end
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 2000) begin
			n_errors++;
			results();
		end
	end
endmodule : board_control_status_registers_test
bind board_control_status_registers board_control_status_registers_checker
	i_board_control_status_registers_checker (.*);

// file: board_regs_pkg.sv
// constants for the board control and status register bank
package board_regs_pkg;
	localparam int          DATA_W             = 16;
	localparam int          ADDR_W             = 22;
	localparam int          REG_W              = 8;
	localparam logic [21:0] BANK_BASE          = 22'h300000;
	localparam logic [1:0]  IDX_SWITCH_AND_LED = 2'h0;
	localparam logic [1:0]  IDX_CARD_CONTROL   = 2'h1;
	localparam logic [1:0]  IDX_BOARD_REV      = 2'h2;
	localparam logic [1:0]  IDX_ROUTING_POWER  = 2'h3;
	localparam logic [7:0]  RESET_BYTE         = 8'h00;
	localparam int          LAMP_LSB           = 0;
	localparam int          SWITCH_LSB         = 4;
	localparam int          CARD_CTRL_LSB      = 0;
	localparam int          CARD_RESET_BIT     = 3;
	localparam int          CARD_STATUS_LSB    = 4;
	localparam int          CARD_PRESENT_BIT   = 7;
	localparam int          BOARD_REV_LSB      = 0;
	localparam int          LOGIC_REV_LSB      = 4;
	localparam int          PORT_SEL_LSB       = 0;
	localparam int          TIMER_DIR_LSB      = 2;
	localparam int          MON_MASK_BIT       = 4;
	localparam int          POWER_GOOD_BIT     = 5;
endpackage : board_regs_pkg

// file: host_model.sv
// host processor model on the asynchronous memory bus
`timescale 1ns/100ps
module host_model
	import board_regs_pkg::*;
(
	input  wire logic              core_clk,
	input  wire logic [DATA_W-1:0] bus_rdata,
	output logic      [ADDR_W-1:0] bus_addr,
	output logic      [DATA_W-1:0] bus_wdata,
	output logic                   bus_select_n, bus_read_n, bus_write_n
);
	initial {bus_select_n, bus_read_n, bus_write_n, bus_addr, bus_wdata} = '1;
	task automatic acc(input logic w, input logic [2:0] i, input logic [7:0] d,
		output logic [15:0] q);
		@(negedge core_clk);
		bus_addr = BANK_BASE + i;
		bus_wdata = {8'hA5, d};
		{bus_select_n, bus_read_n, bus_write_n} = {1'b0, w, !w};
		repeat (5) @(posedge core_clk);
		q = bus_rdata;
		@(negedge core_clk);
		{bus_select_n, bus_read_n, bus_write_n} = 3'h7;
		bus_addr = ~bus_addr;
		bus_wdata = ~bus_wdata;
		repeat (3) @(negedge core_clk);
	endtask : acc
endmodule : host_model
